// [rtl/cpm_counter.v]
// Purpose: Counter measurement block: period, encoder position, edge separation
// Assumes: Inputs synchronous to clk_i; APB slave, one wait state
// Notes: Results go to an internal FIFO; sample-clocked and implicit modes stream them out with valid/ready
//
// What this block does
// - Period between two like gate edges
// - Count source edges between gate edges
// - Position counts only after arming
// - Single-edge: up on A rise, down A fall
// - Double-edge: count every A edge
// - Quad-edge: count every A and B edge
// - Index high in chosen phase loads reload
// - Count change before reload when coincident
// - Reload within one fastest timebase period
// - Two-pulse: up on A rise, down B rise
// - Sample clock captures running count, no reset
// - Sample clock edge rising or falling
// - Buffered results stream to host in sample-clocked and implicit modes
// - Separation starts on aux edge after arm
// - Ignore aux edges while counting
// - Gate edge stops count, stores it
// - Aux and gate polarity independently chosen
// - Single mode idles until result read
// - Implicit mode repeats over intervals
// - Sample-clocked mode pushes on sample edge
// - Missing edges between samples flag overrun
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "cpm_defs.vh"

module cpm_counter #(
	parameter CW = 32,
	parameter FIFO_AW = 4
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	// Counter inputs
	input wire source_i,
	input wire gate_i,
	input wire aux_i,
	input wire phase_a_i,
	input wire phase_b_i,
	input wire index_i,
	input wire sample_i,
	// Result stream to host memory
	output reg [CW-1:0] stream_data_o,
	output reg stream_valid_o,
	input wire stream_ready_i,
	// Status
	output reg armed_o,
	output reg overrun_o
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_WAIT = 4'b0010;
	localparam ST_RUN = 4'b0100;
	localparam ST_DONE = 4'b1000;
	localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};

	function edge_hit;
		input cur;
		input prev;
		input fall;
		begin
			edge_hit = fall ? (prev & ~cur) : (cur & ~prev);
		end
	endfunction

	// Count plus one, minus one or held
	function [CW-1:0] step_cnt;
		input [CW-1:0] v;
		input inc;
		input dec;
		begin
			if (inc)
				step_cnt = v + {{(CW-1){1'b0}}, 1'b1};
			else if (dec)
				step_cnt = v - {{(CW-1){1'b0}}, 1'b1};
			else
				step_cnt = v;
		end
	endfunction

	// Mapped register offsets
	function reg_known;
		input [11:0] addr;
		begin
			case (addr)
				`CPM_OFF_CTRL, `CPM_OFF_CFG, `CPM_OFF_RELOAD, `CPM_OFF_STATUS: reg_known = 1'b1;
				`CPM_OFF_COUNT, `CPM_OFF_RESULT, `CPM_OFF_LEVEL: reg_known = 1'b1;
				default: reg_known = 1'b0;
			endcase
		end
	endfunction

	// Registers
	reg [31:0] cfg_r;
	reg [CW-1:0] reload_r;
	reg [3:0] state_r;
	reg [CW-1:0] count_r;
	reg [CW-1:0] held_r;
	reg held_v_r;
	reg src_q_r;
	reg gate_q_r;
	reg aux_q_r;
	reg a_q_r;
	reg b_q_r;
	reg smp_q_r;

	// FIFO
	reg [CW-1:0] mem_r [0:DEPTH-1];
	reg [FIFO_AW:0] wp_r;
	reg [FIFO_AW:0] rp_r;
	wire [FIFO_AW:0] level = wp_r - rp_r;
	wire fifo_full = (level == DEPTH);
	wire fifo_empty = (level == {(FIFO_AW+1){1'b0}});

	wire [2:0] mode = cfg_r[`CPM_CFG_MODE_HI:`CPM_CFG_MODE_LO];
	wire [1:0] dec = cfg_r[`CPM_CFG_DEC_HI:`CPM_CFG_DEC_LO];
	wire [1:0] zph = cfg_r[`CPM_CFG_ZPH_HI:`CPM_CFG_ZPH_LO];

	wire src_e = edge_hit(source_i, src_q_r, cfg_r[`CPM_CFG_SRC_FALL]);
	wire gate_e = edge_hit(gate_i, gate_q_r, cfg_r[`CPM_CFG_GATE_FALL]);
	wire aux_e = edge_hit(aux_i, aux_q_r, cfg_r[`CPM_CFG_AUX_FALL]);
	wire smp_e = edge_hit(sample_i, smp_q_r, cfg_r[`CPM_CFG_SMP_FALL]);
	wire a_r = phase_a_i & ~a_q_r;
	wire a_f = ~phase_a_i & a_q_r;
	wire b_r = phase_b_i & ~b_q_r;
	wire b_f = ~phase_b_i & b_q_r;

	wire pos_mode = (mode == `CPM_MODE_POS) || (mode == `CPM_MODE_POS_SMP);
	wire sep_mode = (mode == `CPM_MODE_SEP_SINGLE) || (mode == `CPM_MODE_SEP_IMPL) ||
		(mode == `CPM_MODE_SEP_SMP);

	// Quadrature step decode
	reg up, dn;
	always @* begin
		up = 1'b0;
		dn = 1'b0;
		case (dec)
			`CPM_DEC_SINGLE: begin
				up = a_r & ~phase_b_i;
				dn = a_f & ~phase_b_i;
			end
			`CPM_DEC_DOUBLE: begin
				up = (a_r & ~phase_b_i) | (a_f & phase_b_i);
				dn = (a_r & phase_b_i) | (a_f & ~phase_b_i);
			end
			`CPM_DEC_QUAD: begin
				up = (a_r & ~phase_b_i) | (a_f & phase_b_i) | (b_r & phase_a_i) | (b_f & ~phase_a_i);
				dn = (a_r & phase_b_i) | (a_f & ~phase_b_i) | (b_r & ~phase_a_i) | (b_f & phase_a_i);
			end
			default: begin
				up = a_r & ~b_r;
				dn = b_r & ~a_r;
			end
		endcase
	end

	// Phase index: {A,B}; index sampled every clock, fastest timebase
	wire [1:0] cur_ph = {phase_a_i, phase_b_i};
	wire z_hit = cfg_r[`CPM_CFG_ZEN] && index_i && (cur_ph == zph) && (dec != `CPM_DEC_TWO_PULSE);

	// APB decode
	// Taken once, on the edge before ready; the ready cycle must not repeat a pop
	wire acc = psel_i & penable_i & ~pready_o;
	wire wr = acc & pwrite_i;
	wire rd = acc & ~pwrite_i;
	wire hit = reg_known(paddr_i);
	wire arm_wr = wr && (paddr_i == `CPM_OFF_CTRL);
	wire res_rd = rd && (paddr_i == `CPM_OFF_RESULT);
	wire ovr_clr = wr && (paddr_i == `CPM_OFF_STATUS) && pwdata_i[1];

	// Stream pop; a software result read also pops the FIFO, but only while no stream word is held
	wire strm_pop = stream_valid_o & stream_ready_i;
	wire sw_pop = res_rd & ~fifo_empty & ~stream_valid_o;

	// Measurement engine
	reg [3:0] state_nxt;
	reg [CW-1:0] count_nxt;
	reg push;
	reg [CW-1:0] push_d;
	reg [CW-1:0] held_nxt;
	reg held_v_nxt;
	reg ovr_set;
	always @* begin
		state_nxt = state_r;
		count_nxt = count_r;
		push = 1'b0;
		push_d = count_r;
		held_nxt = held_r;
		held_v_nxt = held_v_r;
		ovr_set = 1'b0;
		case (state_r)
			ST_IDLE: begin
			end
			ST_WAIT: begin
				if (pos_mode) begin
					state_nxt = ST_RUN;
				end else if (mode == `CPM_MODE_PERIOD) begin
					if (gate_e) begin
						count_nxt = {CW{1'b0}};
						state_nxt = ST_RUN;
					end
				end else if (sep_mode && aux_e) begin
					count_nxt = {CW{1'b0}};
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (pos_mode) begin
					count_nxt = step_cnt(count_r, up, dn);
					if (z_hit)
						count_nxt = reload_r;
					if (mode == `CPM_MODE_POS_SMP && smp_e) begin
						push = 1'b1;
						push_d = count_r;
					end
				end else if (mode == `CPM_MODE_PERIOD) begin
					if (gate_e) begin
						push = 1'b1;
						push_d = count_r + {{(CW-1){1'b0}}, src_e};
						count_nxt = {CW{1'b0}};
					end else if (src_e) begin
						count_nxt = count_r + {{(CW-1){1'b0}}, 1'b1};
					end
				end else if (sep_mode) begin
					// Aux edges are not looked at here
					if (gate_e) begin
						push_d = count_r + {{(CW-1){1'b0}}, src_e};
						if (mode == `CPM_MODE_SEP_SMP) begin
							held_nxt = push_d;
							held_v_nxt = 1'b1;
						end else begin
							push = 1'b1;
						end
						state_nxt = (mode == `CPM_MODE_SEP_SINGLE) ? ST_DONE : ST_WAIT;
					end else if (src_e) begin
						count_nxt = count_r + {{(CW-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_DONE: begin
				if (res_rd)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (mode == `CPM_MODE_SEP_SMP && state_r != ST_IDLE && smp_e) begin
			if (held_v_r || (held_v_nxt && state_r == ST_RUN)) begin
				push = 1'b1;
				push_d = held_nxt;
				held_v_nxt = 1'b0;
			end else begin
				ovr_set = 1'b1;
			end
		end
		if (arm_wr) begin
			state_nxt = pwdata_i[`CPM_CTRL_ARM] ? ST_WAIT : ST_IDLE;
			count_nxt = {CW{1'b0}};
			held_v_nxt = 1'b0;
		end
	end

	// Input history for edge detection
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_q_r <= 1'b0;
			gate_q_r <= 1'b0;
			aux_q_r <= 1'b0;
			a_q_r <= 1'b0;
			b_q_r <= 1'b0;
			smp_q_r <= 1'b0;
		end else begin
			src_q_r <= source_i;
			gate_q_r <= gate_i;
			aux_q_r <= aux_i;
			a_q_r <= phase_a_i;
			b_q_r <= phase_b_i;
			smp_q_r <= sample_i;
		end
	end

	// Software configuration
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			cfg_r <= `CPM_CFG_RESET;
			reload_r <= {CW{1'b0}};
		end else begin
			if (wr && paddr_i == `CPM_OFF_CFG)
				cfg_r <= pwdata_i;
			if (wr && paddr_i == `CPM_OFF_RELOAD)
				reload_r <= pwdata_i[CW-1:0];
		end
	end

	// Measurement state and status
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			count_r <= {CW{1'b0}};
			held_r <= {CW{1'b0}};
			held_v_r <= 1'b0;
			armed_o <= 1'b0;
			overrun_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
			held_r <= held_nxt;
			held_v_r <= held_v_nxt;
			armed_o <= (state_nxt != ST_IDLE);
			// Set wins over clear; a result lost to a full FIFO sets it too
			overrun_o <= ovr_set | (push & fifo_full) | (overrun_o & ~ovr_clr);
		end
	end

	// Result FIFO and stream head register
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wp_r <= {(FIFO_AW+1){1'b0}};
			rp_r <= {(FIFO_AW+1){1'b0}};
			stream_data_o <= {CW{1'b0}};
			stream_valid_o <= 1'b0;
		end else begin
			if (push && !fifo_full) begin
				mem_r[wp_r[FIFO_AW-1:0]] <= push_d;
				wp_r <= wp_r + {{FIFO_AW{1'b0}}, 1'b1};
			end
			if (sw_pop) begin
				rp_r <= rp_r + {{FIFO_AW{1'b0}}, 1'b1};
			end else if ((!stream_valid_o || strm_pop) && !fifo_empty && mode != `CPM_MODE_SEP_SINGLE &&
				mode != `CPM_MODE_PERIOD && mode != `CPM_MODE_POS) begin
				stream_data_o <= mem_r[rp_r[FIFO_AW-1:0]];
				stream_valid_o <= 1'b1;
				rp_r <= rp_r + {{FIFO_AW{1'b0}}, 1'b1};
			end else if (strm_pop) begin
				stream_valid_o <= 1'b0;
			end
		end
	end

	// APB: one-cycle ready in the access phase
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= acc;
			pslverr_o <= acc & ~hit;
			prdata_o <= 32'h00000000;
			if (rd) begin
				case (paddr_i)
					`CPM_OFF_CTRL: prdata_o <= {31'h00000000, armed_o};
					`CPM_OFF_CFG: prdata_o <= cfg_r;
					`CPM_OFF_RELOAD: prdata_o <= reload_r;
					`CPM_OFF_STATUS: prdata_o <= {28'h0000000, fifo_full, fifo_empty, overrun_o, armed_o};
					`CPM_OFF_COUNT: prdata_o <= count_r;
					`CPM_OFF_RESULT: prdata_o <= fifo_empty ? 32'h00000000 : mem_r[rp_r[FIFO_AW-1:0]];
					`CPM_OFF_LEVEL: prdata_o <= {{(31-FIFO_AW){1'b0}}, level};
					default: prdata_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // cpm_counter

// [common/cpm_defs.vh]
// Purpose: Constants for the counter measurement block
// Assumes: APB word registers, 32-bit data
// Notes: Byte offsets, field positions and reset values
`ifndef CPM_DEFS_VH
`define CPM_DEFS_VH

`define CPM_OFF_CTRL 12'h000
`define CPM_OFF_CFG 12'h004
`define CPM_OFF_RELOAD 12'h008
`define CPM_OFF_STATUS 12'h00c
`define CPM_OFF_COUNT 12'h010
`define CPM_OFF_RESULT 12'h014
`define CPM_OFF_LEVEL 12'h018

`define CPM_CTRL_ARM 0
`define CPM_CFG_MODE_LO 0
`define CPM_CFG_MODE_HI 2
`define CPM_CFG_DEC_LO 3
`define CPM_CFG_DEC_HI 4
`define CPM_CFG_SRC_FALL 5
`define CPM_CFG_GATE_FALL 6
`define CPM_CFG_AUX_FALL 7
`define CPM_CFG_SMP_FALL 8
`define CPM_CFG_ZPH_LO 9
`define CPM_CFG_ZPH_HI 10
`define CPM_CFG_ZEN 11

`define CPM_MODE_PERIOD 3'h0
`define CPM_MODE_POS 3'h1
`define CPM_MODE_POS_SMP 3'h2
`define CPM_MODE_SEP_SINGLE 3'h3
`define CPM_MODE_SEP_IMPL 3'h4
`define CPM_MODE_SEP_SMP 3'h5

`define CPM_DEC_SINGLE 2'h0
`define CPM_DEC_DOUBLE 2'h1
`define CPM_DEC_QUAD 2'h2
`define CPM_DEC_TWO_PULSE 2'h3

`define CPM_CFG_RESET 32'h00000000
`define CPM_RELOAD_RESET 32'h00000000

`endif

// [test/cpm_enc_model.sv]
// Purpose: Encoder model for the counter inputs
// Assumes: Step requests spaced by several clocks
// Notes: Index high only while q_r is 0, which is A=0 and B=0 outside two-pulse mode
`timescale 1ns/10ps
module cpm_enc_model (
	// Control
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic fwd_i,
	input wire logic two_i,
	input wire logic idx_en_i,
	// Encoder lines
	output wire logic phase_a_o,
	output wire logic phase_b_o,
	output wire logic index_o
);
	logic [1:0] q_r = 2'h0;
	logic pa_r = 1'b0;
	logic pb_r = 1'b0;
	always @(posedge clk_i) begin
		if (step_i && !two_i)
			q_r <= fwd_i ? q_r + 2'h1 : q_r - 2'h1;
		pa_r <= step_i && fwd_i;
		pb_r <= step_i && !fwd_i;
	end
	// Forward: A leads B
	assign phase_a_o = two_i ? pa_r : (q_r == 2'h1 || q_r == 2'h2);
	assign phase_b_o = two_i ? pb_r : q_r[1];
	assign index_o = idx_en_i && q_r == 2'h0;
endmodule // cpm_enc_model

// [test/cpm_counter_chk.sv]
// Purpose: Port checker for the counter block
// Assumes: Single clock domain
// Notes: Attached by bind below
`timescale 1ns/10ps
module cpm_counter_chk #(
	parameter CW = 32
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// APB
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	// Stream and status
	input wire [CW-1:0] stream_data_o,
	input wire stream_valid_o,
	input wire stream_ready_i,
	input wire armed_o,
	input wire overrun_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_taken;
		psel_i && penable_i && !pready_o;
	endsequence
	a_apb_answer: assert property (s_taken |=> pready_o) else $error("no ready after access");
	a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
	a_ready_cause: assert property ($rose(pready_o) |-> $past(psel_i && penable_i)) else $error("ready without access");
	a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error response");
	a_stream_hold: assert property (stream_valid_o && !stream_ready_i |=> stream_valid_o && $stable(stream_data_o))
		else $error("stream word dropped");
	a_overrun_sticky: assert property (overrun_o && !(psel_i && pwrite_i) |=> overrun_o)
		else $error("overrun cleared");
	a_arm_write: assert property ($rose(armed_o) |-> $past(psel_i && penable_i && pwrite_i))
		else $error("armed without write");
	a_idle_access: assert property ($fell(armed_o) |-> $past(psel_i && penable_i))
		else $error("disarmed without access");
	a_reset_idle: assert property ($rose(rst_n_i) |-> !armed_o && !overrun_o && !stream_valid_o)
		else $error("outputs busy after reset");
endmodule // cpm_counter_chk
bind cpm_counter cpm_counter_chk #(.CW(CW)) u_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .prdata_o,
	.pready_o, .pslverr_o, .stream_data_o, .stream_valid_o, .stream_ready_i, .armed_o, .overrun_o);

// [test/tb.sv]
// Purpose: Self-checking bench for the counter block
// Assumes: APB with one wait state
// Notes: ev bits are source, gate, aux, sample
`timescale 1ns/10ps
`include "cpm_defs.vh"
module tb;
	logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, stream_data_o, rd;
	logic pready_o, pslverr_o, stream_valid_o, armed_o, overrun_o, err;
	logic stream_ready_i = 1'b0, step = 1'b0, fwd = 1'b1, two = 1'b0, idx_en = 1'b0, pa, pb, idx;
	logic [3:0] ev = 4'h0;
	int num_errors = 0, n_compared = 0;
	cpm_counter dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .source_i(ev[0]), .gate_i(ev[1]), .aux_i(ev[2]), .phase_a_i(pa), .phase_b_i(pb),
		.index_i(idx), .sample_i(ev[3]), .stream_data_o, .stream_valid_o, .stream_ready_i, .armed_o, .overrun_o);
	cpm_enc_model enc (.clk_i, .step_i(step), .fwd_i(fwd), .two_i(two), .idx_en_i(idx_en), .phase_a_o(pa),
		.phase_b_o(pb), .index_o(idx));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		tick(1);
		penable_i <= 1'b1;
		// Only the watchdog ends a wait for ready
		do begin
			tick(1);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		tick(1);
	endtask
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			ev[k] <= 1'b1;
			tick(2);
			ev[k] <= 1'b0;
			tick(2);
		end
	endtask
	task automatic stp(input logic f, input int n);
		repeat (n) begin
			step <= 1'b1;
			fwd <= f;
			tick(1);
			step <= 1'b0;
			tick(3);
		end
	endtask
	task automatic getw(input logic [31:0] e);
		stream_ready_i <= 1'b1;
		do begin
			tick(1);
		end while (stream_valid_o !== 1'b1);
		chk(stream_data_o, e);
		stream_ready_i <= 1'b0;
		tick(1);
	endtask
	task automatic sepi(input int a, input int b);
		pulse(2, 1);
		pulse(0, a);
		pulse(2, 1);
		pulse(0, b);
		pulse(1, 1);
	endtask
	task automatic mode(input logic [31:0] c);
		apb(1'b1, `CPM_OFF_CTRL, 32'h0);
		apb(1'b1, `CPM_OFF_CFG, c);
	endtask
	task automatic end_of_test;
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_period;
		mode(32'h0);
		apb(1'b1, `CPM_OFF_CTRL, 32'h1);
		pulse(1, 1);
		pulse(0, 5);
		pulse(1, 1);
		pulse(0, 3);
		pulse(1, 1);
		apb(1'b0, `CPM_OFF_RESULT, 32'h0);
		chk(rd, 32'h5);
		apb(1'b0, `CPM_OFF_RESULT, 32'h0);
		chk(rd, 32'h3);
	endtask
	task automatic t_pos;
		for (int d = 0; d < 3; d++) begin
			mode(32'h1 | (d << 3));
			apb(1'b1, `CPM_OFF_CTRL, 32'h1);
			stp(1'b1, 8);
			stp(1'b0, 4);
			apb(1'b0, `CPM_OFF_COUNT, 32'h0);
			chk(rd, 32'h1 << d);
			// Disarming also clears the count
			apb(1'b1, `CPM_OFF_CTRL, 32'h0);
			stp(1'b1, 4);
			apb(1'b0, `CPM_OFF_COUNT, 32'h0);
			chk(rd, 32'h0);
		end
		two <= 1'b1;
		mode(32'h19);
		apb(1'b1, `CPM_OFF_CTRL, 32'h1);
		stp(1'b1, 3);
		stp(1'b0, 1);
		apb(1'b0, `CPM_OFF_COUNT, 32'h0);
		chk(rd, 32'h2);
		two <= 1'b0;
		apb(1'b1, `CPM_OFF_RELOAD, 32'h55);
		idx_en <= 1'b1;
		mode(32'h811);
		apb(1'b1, `CPM_OFF_CTRL, 32'h1);
		stp(1'b1, 4);
		apb(1'b0, `CPM_OFF_COUNT, 32'h0);
		chk(rd, 32'h55);
		idx_en <= 1'b0;
		stp(1'b1, 1);
		apb(1'b0, `CPM_OFF_COUNT, 32'h0);
		chk(rd, 32'h56);
	endtask
	task automatic t_sample;
		mode(32'h112);
		apb(1'b1, `CPM_OFF_CTRL, 32'h1);
		stp(1'b1, 2);
		ev[3] <= 1'b1;
		tick(4);
		chk(stream_valid_o, 32'h0);
		ev[3] <= 1'b0;
		stp(1'b1, 1);
		pulse(3, 1);
		getw(32'h2);
		getw(32'h3);
	endtask
	task automatic t_sep;
		mode(32'h84);
		pulse(2, 1);
		pulse(0, 2);
		apb(1'b1, `CPM_OFF_CTRL, 32'h1);
		sepi(3, 2);
		getw(32'h5);
		sepi(0, 2);
		getw(32'h2);
		mode(32'h83);
		apb(1'b1, `CPM_OFF_CTRL, 32'h1);
		sepi(4, 0);
		sepi(2, 0);
		apb(1'b0, `CPM_OFF_LEVEL, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, `CPM_OFF_RESULT, 32'h0);
		chk(rd, 32'h4);
		chk(armed_o, 32'h0);
		mode(32'h85);
		apb(1'b1, `CPM_OFF_CTRL, 32'h1);
		sepi(3, 0);
		tick(4);
		chk(stream_valid_o, 32'h0);
		pulse(3, 1);
		getw(32'h3);
		pulse(3, 1);
		chk(overrun_o, 32'h1);
		apb(1'b1, `CPM_OFF_STATUS, 32'h2);
		chk(overrun_o, 32'h0);
	endtask
	initial begin
		#200000;
		num_errors++;
		end_of_test;
	end
	initial begin
		tick(16);
		rst_n_i <= 1'b1;
		tick(1);
		apb(1'b0, `CPM_OFF_CFG, 32'h0);
		chk(rd, `CPM_CFG_RESET);
		apb(1'b0, 12'h100, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		t_period;
		t_pos;
		t_sample;
		t_sep;
		end_of_test;
	end
endmodule // tb
